// ### wcs_pkg.sv
package wcs_pkg;

	// Clock and cycle timing
	localparam int MCLK_MHZ   = 200;
	localparam int SHORT_NS   = 140;
	localparam int MEDIUM_NS  = 200;
	localparam int LONG_NS    = 300;
	localparam int RAM_WR_NS  = 100;
	localparam int CNT_W      = 6;

	// Least times round up to whole cycles
	localparam int SHORT_CYC  = (SHORT_NS * MCLK_MHZ + 999) / 1000;
	localparam int MEDIUM_CYC = (MEDIUM_NS * MCLK_MHZ + 999) / 1000;
	localparam int LONG_CYC   = (LONG_NS * MCLK_MHZ + 999) / 1000;
	localparam int RAM_WR_CYC = (RAM_WR_NS * MCLK_MHZ + 999) / 1000;

	localparam logic [CNT_W-1:0] SHORT_LAST  = CNT_W'(SHORT_CYC - 1);
	localparam logic [CNT_W-1:0] MEDIUM_LAST = CNT_W'(MEDIUM_CYC - 1);
	localparam logic [CNT_W-1:0] LONG_LAST   = CNT_W'(LONG_CYC - 1);
	localparam logic [CNT_W-1:0] RAM_WR_LAST = CNT_W'(RAM_WR_CYC - 1);

	// Widths and sizes
	localparam int UWORD_W     = 80;
	localparam int HOST_W      = 56;
	localparam int DATA_W      = 16;
	localparam int RAM_ROWS    = 1024;
	localparam int RAM_LANES   = 5;
	localparam int ROW_W       = 10;
	localparam int LANE_W      = 3;
	localparam int PROM_WORDS  = 32;
	localparam int PROM_AW     = 5;
	localparam int STACK_DEPTH = 16;
	localparam int SP_W        = 4;
	localparam int CADDR_W     = 11;
	localparam int PROC_AW     = 9;
	localparam int XADDR_W     = 3;
	localparam int NEXT_W      = 8;
	localparam int ROT_W       = 4;

	// Extended microword fields
	localparam int LIT_LSB        = 64;
	localparam int COUT_SEL_LSB   = 78;
	localparam int STACK_EN_BIT   = 77;
	localparam int CARRY_CHAIN_BIT = 76;
	localparam int LMASK_LSB      = 72;
	localparam int RMASK_LSB      = 68;
	localparam int ROT_LSB        = 64;
	localparam int XADDR_LSB      = 61;
	localparam int DMC_LSB        = 56;
	localparam int NEXT_LSB       = 48;
	localparam int TOP_LANE       = 4;

	// Control address map
	localparam logic [CADDR_W-1:0] PROM_BASE = 11'h100;
	localparam logic [CADDR_W-1:0] PROM_END  = 11'h200;
	localparam logic [CADDR_W-1:0] RAM_BASE  = 11'h400;

	// Stack-top byte address as RAM data address
	localparam int DADDR_HALF_BIT = 14;
	localparam int DADDR_ROW_LSB  = 3;
	localparam int DADDR_LANE_LSB = 1;

	// Register bus map
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_ADDR   = 8'h08;
	localparam logic [7:0] REG_TOP    = 8'h0C;
	localparam int CTRL_RUN_BIT = 0;
	localparam logic CTRL_RUN_RESET = 1'b1;

	typedef enum logic [4:0] {
		DMC_NOP        = 5'h00,
		DMC_PUSH_DATA  = 5'h01,
		DMC_PUSH_LIT   = 5'h02,
		DMC_STK_TO_DIN = 5'h03,
		DMC_STK_TO_BR  = 5'h04,
		DMC_LIT_TO_DIN = 5'h05,
		DMC_LIT_TO_BR  = 5'h06,
		DMC_RAM_WR     = 5'h07,
		DMC_RAM_RD     = 5'h08
	} dmc_t;

	typedef enum logic [1:0] {
		CYC_SHORT  = 2'h0,
		CYC_MEDIUM = 2'h1,
		CYC_LONG   = 2'h2
	} cyc_len_t;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_RUN  = 1'b1
	} phase_t;

	typedef struct packed {
		logic                cyc;
		logic                stb;
		logic                we;
		logic [7:0]          adr;
		logic [3:0]          sel;
		logic [31:0]         dat;
	} wb_req_t;

	typedef struct packed {
		logic                ack;
		logic [31:0]         dat;
	} wb_rsp_t;

	typedef struct packed {
		logic [PROC_AW-1:0]  processorNextAddress;
		logic [HOST_W-1:0]   romWord;
		logic [DATA_W-1:0]   processorDataOutBus;
		logic [3:0]          carryCandidates;
		cyc_len_t            cycleLen;
		logic                unusedOpcode;
		logic                clockRun;
	} host_in_t;

	typedef struct packed {
		logic [HOST_W-1:0]   hostWord;
		logic [CADDR_W-1:0]  controlAddr;
		logic [DATA_W-1:0]   processorDataIn;
		logic                dLoad;
		logic [NEXT_W-1:0]   branchModifierLines;
		logic                branchValid;
		logic [1:0]          carryOutSelect;
		logic                carryChain;
		logic                savedCarry;
		logic                firstPulse;
		logic                secondPulse;
		logic                thirdPulse;
		logic                instrEnd;
		logic                romSelect;
		logic                promSelect;
		logic                addrMuxStack;
	} host_out_t;

	typedef struct packed {
		phase_t              phase;
		logic [CNT_W-1:0]    cnt;
		logic [UWORD_W-1:0]  extendedMicroword;
		logic [SP_W-1:0]     sp;
		logic                prevRam;
		logic                ctrlRun;
		host_out_t           hostOut;
		wb_rsp_t             wbOut;
	} state_t;

endpackage

// ### writable_control_store_extension.sv
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// How it works
// - Microword is 80 bits: 56 to the host datapath, 24 for the extension.
// - RAM is 1024x80 for fetch and 5120x16 for data access.
// - Fetch address joins the host's 9-bit address with 3 extended bits.
// - Data mode addresses by stack top; writes take data-out bus, reads feed D.
// - A 32-word boot PROM can read, write and run the RAM.
// - 16x16 stack, microcode push/pop, input from data-out bus or source mux.
// - Stack goes through source mux, rotator, mask to data-in or branch lines.
// - Literal can be pushed for linkage; stack top later drives branch lines.
// - Rotator turns the source mux output, or RAM data on a read, right by 0 to 15.
// - Mask clears programmed counts of bits at the left and right ends.
// - Next address field sits in bits 55:48, forming an 11-bit address.
// - Map: 256 ROM, 256 PROM (32 words mirrored), 512 unused, 1024 RAM words.
// - 5-bit misc code decodes operations; literal use disables top-16 controls.
// - Without literal, bits 75:64 hold left mask, right mask, rotate count.
// - Bit 76 feeds saved carry to the ALU and saves the new one at end.
// - Bit 77: push predecrements pointer; pop increments at instruction end.
// - Bits 79:78 drive the carry-out select directly.
// - Fetch after a RAM access comes from PROM; PROM is never data.
// - Stack top is a byte address: bits 14,2:1 pick lane, 12:3 the row.
// - RAM write happens 100 ns into the instruction, stack addressing.
// - RAM read reaches D at the second pulse; PROM and mux return there.
// - Unused opcode jumps to PROM 0; PROM answers addresses 256 to 511.
// - Long cycle lasts 300 ns and gives the second and third pulses.
module writable_control_store_extension
#(
	parameter logic [wcs_pkg::UWORD_W-1:0] PROM_IMAGE [wcs_pkg::PROM_WORDS] = '{default: '0}
)
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire wcs_pkg::host_in_t hostIn,
	output wcs_pkg::host_out_t     hostOut,
	input  wire wcs_pkg::wb_req_t  wbIn,
	output wcs_pkg::wb_rsp_t       wbOut
);
	import wcs_pkg::*;

	state_t                 st_ff;
	state_t                 nxt_st;

	// Storage arrays; no reset, contents are lost at power-off anyway
	logic [DATA_W-1:0]      ramMem [RAM_LANES][RAM_ROWS];
	logic [DATA_W-1:0]      stackMem [STACK_DEPTH];

	logic                   ramWrEn;
	logic [LANE_W-1:0]      ramLane;
	logic [ROW_W-1:0]       ramRow;
	logic                   laneValid;
	logic                   stkWrEn;
	logic [SP_W-1:0]        stkWrAddr;
	logic [DATA_W-1:0]      stkWrData;

	dmc_t                   destinationMiscCode;
	logic                   literalInUse;
	logic [DATA_W-1:0]      literalField;
	logic [DATA_W-1:0]      stackTop;
	logic [DATA_W-1:0]      stackSourceMux;
	logic [DATA_W-1:0]      ramData;
	logic [DATA_W-1:0]      shiftSource;
	logic [2*DATA_W-1:0]    rotDouble;
	logic [DATA_W-1:0]      rotated;
	logic [DATA_W-1:0]      masked;
	logic [ROT_W-1:0]       rotCount;
	logic [ROT_W-1:0]       leftMask;
	logic [ROT_W-1:0]       rightMask;
	logic                   isRamOp;
	logic                   stackEnable;
	logic                   carryChainEn;
	logic [1:0]             carryOutSelect;
	logic [CADDR_W-1:0]     nextControlAddr;
	logic [UWORD_W-1:0]     fetchedWord;
	logic [CNT_W-1:0]       endCnt;
	logic                   atEnd;
	logic                   atSecond;
	logic                   longCycle;
	logic                   wbHit;
	logic [31:0]            wbReadData;

	// Top 16 bits of the microword are either literal or control fields
	// misc decode
	always_comb
	begin
		destinationMiscCode = dmc_t'(st_ff.extendedMicroword[DMC_LSB +: 5]);
		literalInUse = (destinationMiscCode == DMC_PUSH_LIT)
			|| (destinationMiscCode == DMC_LIT_TO_DIN)
			|| (destinationMiscCode == DMC_LIT_TO_BR);
		isRamOp = (destinationMiscCode == DMC_RAM_WR)
			|| (destinationMiscCode == DMC_RAM_RD);
	end

	assign literalField = st_ff.extendedMicroword[LIT_LSB +: DATA_W];

	assign leftMask  = literalInUse ? '0 : st_ff.extendedMicroword[LMASK_LSB +: ROT_W];
	assign rightMask = literalInUse ? '0 : st_ff.extendedMicroword[RMASK_LSB +: ROT_W];
	assign rotCount  = literalInUse ? '0 : st_ff.extendedMicroword[ROT_LSB +: ROT_W];

	// carry chain bit, suppressed under literal
	assign carryChainEn = !literalInUse && st_ff.extendedMicroword[CARRY_CHAIN_BIT];
	assign stackEnable = !literalInUse && st_ff.extendedMicroword[STACK_EN_BIT];
	assign carryOutSelect = literalInUse ? 2'h0 : st_ff.extendedMicroword[COUT_SEL_LSB +: 2];

	assign stackTop = stackMem[st_ff.sp];

	// stack source mux picks literal or stack top
	assign stackSourceMux = literalInUse ? literalField : stackTop;

	// byte address split into lane and row
	always_comb
	begin
		ramRow  = stackTop[DADDR_ROW_LSB +: ROW_W];
		ramLane = stackTop[DADDR_HALF_BIT] ? LANE_W'(TOP_LANE)
			: {1'b0, stackTop[DADDR_LANE_LSB +: 2]};
		// Addresses with bit 14 set and bits 2:1 nonzero neither read nor write
		laneValid = !(stackTop[DADDR_HALF_BIT] && (stackTop[DADDR_LANE_LSB +: 2] != 2'h0));
		ramData = laneValid ? ramMem[ramLane][ramRow] : '0;
	end

	always_comb
	begin
		shiftSource = (destinationMiscCode == DMC_RAM_RD) ? ramData : stackSourceMux;
		rotDouble = {shiftSource, shiftSource} >> rotCount;
		rotated = rotDouble[DATA_W-1:0];
	end

	always_comb
	begin
		for (int i = 0; i < DATA_W; i++)
		begin
			masked[i] = rotated[i] && (i >= int'(rightMask))
				&& (i < DATA_W - int'(leftMask));
		end
	end

	// 3 extended bits widen the host's next address
	// unused opcode forces PROM word 0
	always_comb
	begin
		if (hostIn.unusedOpcode)
		begin
			nextControlAddr = PROM_BASE;
		end
		else
		begin
			nextControlAddr = {st_ff.extendedMicroword[XADDR_LSB +: XADDR_W], 8'h00}
				| {2'b00, hostIn.processorNextAddress};
		end
	end

	// boot PROM and address space decode
	// PROM path bypasses the mux after a RAM access
	always_comb
	begin
		fetchedWord = '0;
		if (isRamOp)
		begin
			fetchedWord = PROM_IMAGE[nextControlAddr[PROM_AW-1:0]];
		end
		else if (nextControlAddr < PROM_BASE)
		begin
			fetchedWord = {{(UWORD_W-HOST_W){1'b0}}, hostIn.romWord};
		end
		else if (nextControlAddr < PROM_END)
		begin
			// PROM mirrors through 256 to 511
			fetchedWord = PROM_IMAGE[nextControlAddr[PROM_AW-1:0]];
		end
		else if (nextControlAddr >= RAM_BASE)
		begin
			// five 16-bit lanes form one 80-bit word
			for (int l = 0; l < RAM_LANES; l++)
			begin
				fetchedWord[l*DATA_W +: DATA_W] = ramMem[l][nextControlAddr[ROW_W-1:0]];
			end
		end
	end

	// RAM access forces the long cycle
	always_comb
	begin
		longCycle = isRamOp || (hostIn.cycleLen == CYC_LONG);
		if (longCycle)
		begin
			endCnt = LONG_LAST;
		end
		else if (hostIn.cycleLen == CYC_MEDIUM)
		begin
			endCnt = MEDIUM_LAST;
		end
		else
		begin
			endCnt = SHORT_LAST;
		end
		atEnd = (st_ff.phase == PH_RUN) && (st_ff.cnt == endCnt);
		atSecond = (st_ff.phase == PH_RUN) && longCycle && (st_ff.cnt == SHORT_LAST);
	end

	always_comb
	begin
		wbHit = wbIn.cyc && wbIn.stb && !st_ff.wbOut.ack;
		unique case (wbIn.adr)
			REG_CTRL:   wbReadData = {31'h0, st_ff.ctrlRun};
			REG_STATUS: wbReadData = {24'h0, st_ff.prevRam, st_ff.phase,
				st_ff.hostOut.savedCarry, 1'b0, st_ff.sp};
			REG_ADDR:   wbReadData = {21'h0, st_ff.hostOut.controlAddr};
			REG_TOP:    wbReadData = {16'h0, stackTop};
			default:    wbReadData = 32'h0;
		endcase
	end

	always_comb
	begin
		nxt_st = st_ff;
		ramWrEn = 1'b0;
		stkWrEn = 1'b0;
		stkWrAddr = st_ff.sp;
		stkWrData = hostIn.processorDataOutBus;

		nxt_st.hostOut.firstPulse = 1'b0;
		nxt_st.hostOut.secondPulse = 1'b0;
		nxt_st.hostOut.thirdPulse = 1'b0;
		nxt_st.hostOut.instrEnd = 1'b0;
		nxt_st.hostOut.dLoad = 1'b0;
		nxt_st.hostOut.branchValid = 1'b0;

		// 56 bits drive the host datapath
		nxt_st.hostOut.hostWord = st_ff.extendedMicroword[HOST_W-1:0];
		nxt_st.hostOut.carryOutSelect = carryOutSelect;
		nxt_st.hostOut.carryChain = carryChainEn;

		// Ack one cycle after the strobe; a write lands on the ack edge
		nxt_st.wbOut.ack = wbHit;
		nxt_st.wbOut.dat = wbHit ? wbReadData : '0;
		if (st_ff.wbOut.ack && wbIn.stb && wbIn.we && (wbIn.adr == REG_CTRL) && wbIn.sel[0])
		begin
			nxt_st.ctrlRun = wbIn.dat[CTRL_RUN_BIT];
		end

		unique case (st_ff.phase)
			PH_IDLE:
			begin
				nxt_st.cnt = '0;
				if (hostIn.clockRun && st_ff.ctrlRun)
				begin
					nxt_st.phase = PH_RUN;
				end
			end
			PH_RUN:
			begin
				nxt_st.cnt = CNT_W'(st_ff.cnt + 1'b1);
				// every RAM op takes the stack as address
				if (isRamOp && (st_ff.cnt == '0))
				begin
					nxt_st.hostOut.addrMuxStack = 1'b1;
					nxt_st.hostOut.promSelect = 1'b0;
				end

				if ((destinationMiscCode == DMC_STK_TO_BR)
					|| (destinationMiscCode == DMC_LIT_TO_BR))
				begin
					nxt_st.hostOut.branchModifierLines = masked[NEXT_W-1:0];
				end
				else
				begin
					nxt_st.hostOut.branchModifierLines = '0;
				end

				// RAM write 100 ns into the instruction
				if ((destinationMiscCode == DMC_RAM_WR) && (st_ff.cnt == RAM_WR_LAST))
				begin
					ramWrEn = laneValid;
				end

				// read data into D at the second pulse
				if (atSecond)
				begin
					nxt_st.hostOut.secondPulse = 1'b1;
					nxt_st.hostOut.addrMuxStack = 1'b0;
					nxt_st.hostOut.promSelect = st_ff.hostOut.promSelect || isRamOp;
					if (destinationMiscCode == DMC_RAM_RD)
					begin
						nxt_st.hostOut.processorDataIn = masked;
						nxt_st.hostOut.dLoad = 1'b1;
					end
				end

				if (atEnd)
				begin
					nxt_st.hostOut.instrEnd = 1'b1;
					if (longCycle)
					begin
						nxt_st.hostOut.thirdPulse = 1'b1;
					end
					else if (hostIn.cycleLen == CYC_MEDIUM)
					begin
						nxt_st.hostOut.secondPulse = 1'b1;
					end
					else
					begin
						nxt_st.hostOut.firstPulse = 1'b1;
					end

					// data-in bus loads only the D register
					if ((destinationMiscCode == DMC_STK_TO_DIN)
						|| (destinationMiscCode == DMC_LIT_TO_DIN))
					begin
						nxt_st.hostOut.processorDataIn = masked;
						nxt_st.hostOut.dLoad = 1'b1;
					end
					if ((destinationMiscCode == DMC_STK_TO_BR)
						|| (destinationMiscCode == DMC_LIT_TO_BR))
					begin
						nxt_st.hostOut.branchValid = 1'b1;
					end

					// stack input mux: data-out bus or source mux
					if ((destinationMiscCode == DMC_PUSH_DATA)
						|| (destinationMiscCode == DMC_PUSH_LIT))
					begin
						stkWrEn = 1'b1;
						stkWrData = (destinationMiscCode == DMC_PUSH_LIT)
							? stackSourceMux : hostIn.processorDataOutBus;
						if (stackEnable)
						begin
							stkWrAddr = SP_W'(st_ff.sp - 1'b1);
							nxt_st.sp = stkWrAddr;
						end
					end
					// pop increments at end, wraps silently
					if (stackEnable && ((destinationMiscCode == DMC_STK_TO_DIN)
						|| (destinationMiscCode == DMC_STK_TO_BR)))
					begin
						nxt_st.sp = SP_W'(st_ff.sp + 1'b1);
					end

					// save selected carry for the next chained op
					if (carryChainEn)
					begin
						nxt_st.hostOut.savedCarry = hostIn.carryCandidates[carryOutSelect];
					end

					// Fetch the next microword
					nxt_st.extendedMicroword = fetchedWord;
					nxt_st.prevRam = isRamOp;
					nxt_st.hostOut.controlAddr = nextControlAddr;
					nxt_st.hostOut.romSelect = !isRamOp && (nextControlAddr < PROM_BASE);
					nxt_st.hostOut.promSelect = isRamOp
						|| ((nextControlAddr >= PROM_BASE) && (nextControlAddr < PROM_END));
					nxt_st.hostOut.addrMuxStack = 1'b0;
					nxt_st.cnt = '0;
					if (!(hostIn.clockRun && st_ff.ctrlRun))
					begin
						nxt_st.phase = PH_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff <= '0;
			st_ff.ctrlRun <= CTRL_RUN_RESET;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	// data mode write into one 16-bit lane
	always_ff @(posedge mclk)
	begin
		if (ramWrEn)
		begin
			ramMem[ramLane][ramRow] <= hostIn.processorDataOutBus;
		end
		if (stkWrEn)
		begin
			stackMem[stkWrAddr] <= stkWrData;
		end
	end

	assign hostOut = st_ff.hostOut;
	assign wbOut = st_ff.wbOut;

endmodule

// ### host_sequencer_model.sv
`timescale 1ns/1ps
module host_sequencer_model
(
	input  wire wcs_pkg::host_out_t      hostOut,
	output wcs_pkg::cyc_len_t            cycleLen,
	output logic [wcs_pkg::PROC_AW-1:0]  nextAddr,
	output logic [wcs_pkg::HOST_W-1:0]   romWord
);
	import wcs_pkg::*;

	// Stub ROM: every word is a NOP looping at 0
	assign romWord = '0;

	// next field back, branch lines ORed in
	assign nextAddr = {1'b0, hostOut.hostWord[55:48] | hostOut.branchModifierLines};

	// mixed lengths, so quick and slow answers both occur
	assign cycleLen = hostOut.controlAddr[0] ? CYC_MEDIUM
		: (hostOut.controlAddr[1] ? CYC_SHORT : CYC_LONG);
endmodule

// ### writable_control_store_extension_assertions.sv
`timescale 1ns/1ps
module wcs_checker
(
	input wire logic              mclk,
	input wire logic              resetn,
	input wire wcs_pkg::host_in_t  hostIn,
	input wire wcs_pkg::host_out_t hostOut,
	input wire wcs_pkg::wb_req_t   wbIn,
	input wire wcs_pkg::wb_rsp_t   wbOut
);
	import wcs_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);

	logic ramOp_ff;

	// Remembers a RAM op until its instruction ends
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			ramOp_ff <= 1'b0;
		end
		else if (hostOut.instrEnd)
		begin
			ramOp_ff <= 1'b0;
		end
		else if (hostOut.addrMuxStack)
		begin
			ramOp_ff <= 1'b1;
		end
	end

	AST_ACK_ONE:
		assert property (wbIn.cyc && wbIn.stb && !wbOut.ack |=> wbOut.ack)
		else $error("bus request not acked next cycle");
	AST_ACK_PULSE:
		assert property (wbOut.ack |=> !wbOut.ack)
		else $error("ack held too long");
	AST_DAT_IDLE:
		assert property (!wbOut.ack |-> wbOut.dat == '0)
		else $error("read data without ack");
	AST_LONG_THIRD:
		assert property (hostOut.secondPulse && !hostOut.instrEnd
			|-> ##32 (hostOut.thirdPulse && hostOut.instrEnd))
		else $error("long cycle third pulse misplaced");
	AST_THIRD_END:
		assert property (hostOut.thirdPulse |-> hostOut.instrEnd && !hostOut.secondPulse)
		else $error("third pulse outside instruction end");
	AST_SHORT_END:
		assert property (hostOut.firstPulse |-> hostOut.instrEnd && !hostOut.thirdPulse)
		else $error("short cycle pulse wrong");
	AST_MUX_BACK:
		assert property ($fell(hostOut.addrMuxStack) |-> hostOut.promSelect
			&& (hostOut.secondPulse || $past(hostOut.secondPulse)))
		else $error("address mux returned off second pulse");
	AST_TRAP_PROM:
		assert property (hostOut.instrEnd && $past(hostIn.unusedOpcode)
			|-> hostOut.controlAddr == PROM_BASE)
		else $error("unused opcode did not reach PROM 0");
	AST_RAM_NEXT:
		assert property (hostOut.instrEnd && ramOp_ff
			|-> hostOut.promSelect && !hostOut.romSelect)
		else $error("fetch after RAM op not from PROM");
	AST_BRANCH_END:
		assert property (hostOut.branchValid |-> hostOut.instrEnd)
		else $error("branch lines valid off instruction end");
	AST_DLOAD_AT:
		assert property (hostOut.dLoad |-> hostOut.instrEnd || hostOut.secondPulse)
		else $error("D load outside a pulse");
	AST_MAP:
		assert property (hostOut.instrEnd && !ramOp_ff
			|-> hostOut.romSelect == (hostOut.controlAddr < PROM_BASE)
			&& hostOut.promSelect == (hostOut.controlAddr >= PROM_BASE
			&& hostOut.controlAddr < PROM_END))
		else $error("store select disagrees with address");
	AST_CARRY_SAVE:
		assert property ($changed(hostOut.savedCarry)
			|-> hostOut.instrEnd || $past(hostOut.instrEnd))
		else $error("saved carry moved mid instruction");

	cover property (hostOut.thirdPulse);
	cover property (hostOut.firstPulse);
	cover property (hostOut.dLoad && hostOut.secondPulse);
	cover property (hostOut.addrMuxStack);
endmodule

bind writable_control_store_extension wcs_checker wcs_checker_i
(
	.mclk    (mclk),
	.resetn  (resetn),
	.hostIn  (hostIn),
	.hostOut (hostOut),
	.wbIn    (wbIn),
	.wbOut   (wbOut)
);

// ### writable_control_store_extension_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
	$display("wrong value at %0t: %h vs %h", $time, a, b); end end
module writable_control_store_extension_tb_top;
	import wcs_pkg::*;

	function automatic logic [79:0] w(input logic [4:0] c, input logic [7:0] n,
		input logic [15:0] h);
		return {h, 3'h1, c, n, 48'h0};
	endfunction

	// Push wraps sp to 15, pops back, literal 0x12 is RAM lane 1 row 2
	localparam logic [79:0] IMG [32] = '{
		0: w(DMC_PUSH_DATA, 8'h01, 16'hA000),
		1: w(DMC_STK_TO_DIN, 8'h02, 16'h0325),
		2: w(DMC_STK_TO_DIN, 8'h03, 16'h2000),
		3: w(DMC_PUSH_LIT, 8'h04, 16'h0012),
		4: w(DMC_RAM_WR, 8'h05, 16'h0000),
		5: w(DMC_RAM_RD, 8'h06, 16'h0000),
		6: w(DMC_NOP, 8'h07, 16'h5000),
		7: w(DMC_LIT_TO_BR, 8'h00, 16'h0000),
		default: '0};

	logic                mclk = 1'b0;
	logic                resetn = 1'b0;
	host_in_t            hostIn;
	host_out_t           hostOut;
	wb_req_t             wbIn;
	wb_rsp_t             wbOut;
	cyc_len_t            pLen;
	logic [PROC_AW-1:0]  pNext;
	logic [HOST_W-1:0]   pRom;
	logic [15:0]         dOut;
	logic [3:0]          carry;
	logic                unused;
	logic                run;
	logic [31:0]         rng = 32'hFA4FE687;
	logic [31:0]         rd;
	logic [15:0]         expv;
	logic [15:0]         exq [$];
	int                  fails = 0;
	int                  checked = 0;
	int                  cycles = 0;
	int                  n;

	assign hostIn = '{pNext, pRom, dOut, carry, pLen, unused, run};

	writable_control_store_extension #(.PROM_IMAGE(IMG)) writable_control_store_extension_i
	(
		.mclk    (mclk),
		.resetn  (resetn),
		.hostIn  (hostIn),
		.hostOut (hostOut),
		.wbIn    (wbIn),
		.wbOut   (wbOut)
	);

	host_sequencer_model host_sequencer_model_i
	(
		.hostOut  (hostOut),
		.cycleLen (pLen),
		.nextAddr (pNext),
		.romWord  (pRom)
	);

	always #2.5 mclk = ~mclk;

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	function automatic logic [15:0] rm(input logic [15:0] v, input int r, input int l,
		input int m);
		v = (v >> r) | (v << (16 - r));
		return v & (16'hFFFF >> l) & (16'hFFFF << m);
	endfunction

	task automatic end_of_test();
		if (fails == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Holds the request until ack is seen at an edge
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge mclk);
		wbIn <= '{1'b1, 1'b1, we, a, 4'hF, d};
		do
		begin
			@(posedge mclk);
			k++;
		end
		while (wbOut.ack !== 1'b1 && k < 50);
		if (wbOut.ack !== 1'b1)
			fails++;
		rd = wbOut.dat;
		wbIn <= '0;
	endtask

	// New random pass: same word pushed, written to RAM, read back
	task automatic plan();
		rng = xs(rng);
		dOut <= rng[15:0];
		carry <= rng[19:16];
		exq.push_back(rm(rng[15:0], 5, 3, 2));
		exq.push_back(rng[15:0]);
		exq.push_back(rng[15:0]);
	endtask

	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			fails++;
			end_of_test();
		end
	end

	always @(posedge mclk)
		if (hostOut.dLoad === 1'b1)
		begin
			expv = exq.size() > 0 ? exq.pop_front() : 16'hXXXX;
			`CHK(hostOut.processorDataIn, expv)
		end

	initial
	begin
		wbIn = '0;
		dOut = '0;
		carry = '0;
		unused = 1'b0;
		run = 1'b0;
		repeat (8) @(posedge mclk);
		resetn <= 1'b1;
		wb(1'b0, REG_CTRL, 32'h0);
		`CHK(rd, 32'h1)
		wb(1'b0, REG_STATUS, 32'h0);
		`CHK(rd, 32'h0)
		// Unmapped place: write dropped, reads zero
		wb(1'b1, 8'h20, 32'hFFFFFFFF);
		wb(1'b0, 8'h20, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b1, REG_CTRL, 32'h0);
		wb(1'b0, REG_CTRL, 32'h0);
		`CHK(rd, 32'h0)
		wb(1'b1, REG_CTRL, 32'h1);
		plan();
		@(posedge mclk);
		run <= 1'b1;
		unused <= 1'b1;
		@(posedge mclk iff hostOut.instrEnd === 1'b1);
		unused <= 1'b0;
		repeat (4)
		begin
			@(posedge mclk iff (hostOut.instrEnd === 1'b1 && hostOut.controlAddr === 11'h107));
			`CHK(hostOut.savedCarry, carry[1])
			`CHK(hostOut.carryChain, IMG[6][76])
			`CHK(hostOut.carryOutSelect, IMG[6][79:78])
			`CHK(hostOut.hostWord, IMG[6][55:0])
			`CHK(exq.size(), 0)
			plan();
		end
		// Run bit cleared: block must go idle and stay there
		wb(1'b1, REG_CTRL, 32'h0);
		n = 0;
		do
		begin
			wb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (rd[6] !== 1'b0 && n < 100);
		`CHK(rd[6], 1'b0)
		n = 0;
		repeat (100)
		begin
			@(posedge mclk);
			if (hostOut.instrEnd !== 1'b0)
				n++;
		end
		`CHK(n, 0)
		end_of_test();
	end
endmodule
